// file: rtl/lqta_top.sv
// Register bank of the link quality monitor: threshold access through the
// data register, live parameter sampling, warnings and automatic restart.
// Assumes parameters and status inputs come from logic on clk_sys.
//
// Overview of operation
// - No threshold writes while powered down
// - Data bits 15:14 read zero, ignore writes
// - Sample-enable bit samples selected live parameter
// - Write command stores byte into selected threshold
// - Write command bit always reads zero
// - Select field picks one of six parameters
// - One selector serves sampling and threshold access
// - Select bit picks low or high threshold
// - Variance bytes map to bits 23:16, 31:24
// - Data byte at 7:0 resets to 0x80
// - Sampling off: byte shows selected threshold
// - Sampling on: byte holds sampled value
// - Interrupt on violation only when enabled
// - Variance register read clears, no re-arm
// - Variance restart bit resets DSP on violation
// - Signal detect option zero drops link too
// - Variance high warning sets, clears on read
// - Variance register reserved bits read zero
// - Monitoring only when enabled with 100 Mb link
// - Monitor register read clears warnings, re-arms
`timescale 1ns/1ns
`default_nettype none
`include "lqta_regs.svh"

module lqta_top (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire lqta_pkg::lqta_avmm_req_t avs_req,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Live DSP parameters
  input wire lqta_pkg::lqta_params_t params,
  // Device status
  input wire logic link_up_100,
  input wire logic powered_down,
  input wire logic signal_detect_option,
  input wire logic monitor_irq_enable,
  // Monitor outputs
  output logic monitor_irq,
  output logic dsp_restart,
  output logic link_drop
);

  lqta_pkg::lqta_state_t s_q;
  lqta_pkg::lqta_state_t s_d;

  logic bus_prep;
  logic bus_take;
  logic [4:0] idx;
  logic aligned;
  logic [4:0] hi_raw;
  logic [4:0] lo_raw;
  logic var_raw;

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake
  lqta_avmm_ack u_ack (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .req(avs_req.read | avs_req.write),
    .waitrequest(avs_waitrequest),
    .prep(bus_prep),
    .take(bus_take)
  );

  // Word index; a misaligned address counts as unmapped
  assign idx = avs_req.address[6:2];
  assign aligned = avs_req.address[1:0] == 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // One comparator per byte-wide parameter
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_cmp
      lqta_thr_cmp #(
        .W(8)
      ) u_cmp (
        .value(params.chan[gi]),
        .low(s_q.thr[gi][0]),
        .high(s_q.thr[gi][1]),
        .above(hi_raw[gi]),
        .below(lo_raw[gi])
      );
    end
  endgenerate

  // Variance checks only its upper half against the high pair
  lqta_thr_cmp #(
    .W(16)
  ) u_cmp_var (
    .value(params.variance[31:16]),
    .low(16'h0000),
    .high({s_q.thr[5][1], s_q.thr[5][0]}),
    .above(var_raw),
    .below()
  );

  ////////////////////////////////////////////////////////////////////////////
  // Live value for a select code; variance gives one byte of its upper half
  function automatic logic [7:0] pick_param(
    input lqta_pkg::lqta_params_t p,
    input logic [2:0] psel,
    input logic hl
  );
    logic [7:0] v;
    v = 8'h00;
    case (psel)
      3'h0: v = p.chan[0];
      3'h1: v = p.chan[1];
      3'h2: v = p.chan[2];
      3'h3: v = p.chan[3];
      3'h4: v = p.chan[4];
      3'h5: v = hl ? p.variance[31:24] : p.variance[23:16];
      default: v = 8'h00;
    endcase
    return v;
  endfunction : pick_param

  // Current readback of the monitor register
  function automatic logic [15:0] mon_word(input lqta_pkg::lqta_state_t s);
    return {s.mon_en, s.mon_restart, s.mon_warn};
  endfunction : mon_word

  // Current readback of the data register
  function automatic logic [15:0] data_word(input lqta_pkg::lqta_state_t s);
    logic [7:0] b;
    b = 8'h00;
    if (s.sample_en) begin
      b = s.sample;
    end else if (s.psel < `LQTA_NUM_PSEL) begin
      b = s.thr[s.psel][s.hl];
    end
    // Reserved bits and the write command read as zero
    return {2'h0, s.sample_en, 1'b0, s.psel, s.hl, b};
  endfunction : data_word

  // Current readback of the variance register
  function automatic logic [15:0] var_word(input lqta_pkg::lqta_state_t s);
    return {5'h00, s.var_restart, 8'h00, s.var_warn, 1'b0};
  endfunction : var_word

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  logic mon_live;
  logic [4:0] v_hi;
  logic [4:0] v_lo;
  logic v_var;
  logic [9:0] warn_set;
  logic [9:0] warn_clr;
  logic var_clr;
  logic any_viol;
  logic [4:0] new_ev;
  logic new_var;
  logic restart_ev;
  logic [15:0] cur;
  logic [15:0] mask;
  logic [15:0] w;
  logic rd_take;
  logic wr_take;

  always_comb begin
    s_d = s_q;
    mon_live = 1'b0;
    v_hi = 5'h00;
    v_lo = 5'h00;
    v_var = 1'b0;
    warn_set = 10'h000;
    warn_clr = 10'h000;
    var_clr = 1'b0;
    any_viol = 1'b0;
    new_ev = 5'h00;
    new_var = 1'b0;
    restart_ev = 1'b0;
    cur = 16'h0000;
    mask = 16'h0000;
    w = 16'h0000;
    rd_take = bus_take & avs_req.read;
    wr_take = bus_take & avs_req.write;

    // Violations count only with the monitor on and a 100 Mb link up
    mon_live = s_q.mon_en & link_up_100;
    v_hi = mon_live ? hi_raw : 5'h00;
    v_lo = mon_live ? lo_raw : 5'h00;
    v_var = mon_live & var_raw;
    any_viol = (|v_hi) | (|v_lo) | v_var;

    // Warning layout: channel i high at bit 2i+1, low at bit 2i
    for (int i = 0; i < 5; i++) begin
      warn_set[2*i+1] = v_hi[i];
      warn_set[2*i] = v_lo[i];
    end

    // Read data is registered in the wait state
    if (bus_prep && avs_req.read) begin
      s_d.rdata = 32'h0000_0000;
      if (aligned) begin
        case (idx)
          `LQTA_IDX_MON: s_d.rdata = {16'h0000, mon_word(s_q)};
          `LQTA_IDX_DATA: s_d.rdata = {16'h0000, data_word(s_q)};
          `LQTA_IDX_VAR: s_d.rdata = {16'h0000, var_word(s_q)};
          default: s_d.rdata = 32'h0000_0000;
        endcase
      end
    end

    // Clear only what the read reported, so a bit set meanwhile survives
    if (rd_take && aligned && idx == `LQTA_IDX_MON) begin
      warn_clr = s_q.rdata[9:0];
      s_d.irq = 1'b0;
      s_d.armed = 1'b1;
    end
    if (rd_take && aligned && idx == `LQTA_IDX_VAR) begin
      var_clr = s_q.rdata[`LQTA_V_WARN];
    end

    // Sticky warnings; a set in the clearing cycle wins
    s_d.mon_warn = (s_q.mon_warn & ~warn_clr) | warn_set;
    s_d.var_warn = (s_q.var_warn & ~var_clr) | v_var;

    // Interrupt fires once per arming; a firing beats a same-cycle re-arm
    if (any_viol && s_d.armed && monitor_irq_enable) begin
      s_d.irq = 1'b1;
      s_d.armed = 1'b0;
    end

    // Restart on the first cycle of a violation, not on every cycle of it
    new_ev = (v_hi | v_lo) & ~(s_q.prev_hi | s_q.prev_lo);
    new_var = v_var & ~s_q.prev_var;
    s_d.prev_hi = v_hi;
    s_d.prev_lo = v_lo;
    s_d.prev_var = v_var;
    restart_ev = (|(new_ev & s_q.mon_restart)) | (new_var & s_q.var_restart);
    s_d.restart = restart_ev;
    s_d.link_drop = restart_ev & ~signal_detect_option;

    // Writes merge byte lanes over the current readback
    mask = {{8{avs_req.byteenable[1]}}, {8{avs_req.byteenable[0]}}};
    if (wr_take && aligned) begin
      case (idx)
        `LQTA_IDX_MON: cur = mon_word(s_q);
        `LQTA_IDX_DATA: cur = data_word(s_q);
        `LQTA_IDX_VAR: cur = var_word(s_q);
        default: cur = 16'h0000;
      endcase
      w = (avs_req.writedata[15:0] & mask) | (cur & ~mask);
      case (idx)
        `LQTA_IDX_MON: begin
          s_d.mon_en = w[`LQTA_M_EN];
          s_d.mon_restart = w[`LQTA_M_RST_LO+4:`LQTA_M_RST_LO];
        end
        `LQTA_IDX_DATA: begin
          // Reserved bits and the command bit are not stored
          s_d.sample_en = w[`LQTA_D_SAMPLE];
          s_d.psel = w[`LQTA_D_PSEL_HI:`LQTA_D_PSEL_LO];
          s_d.hl = w[`LQTA_D_HL];
          if (w[`LQTA_D_SAMPLE]) begin
            s_d.sample = pick_param(params, w[`LQTA_D_PSEL_HI:`LQTA_D_PSEL_LO],
                                    w[`LQTA_D_HL]);
          end
          if (w[`LQTA_D_WRCMD] && !powered_down &&
              w[`LQTA_D_PSEL_HI:`LQTA_D_PSEL_LO] < `LQTA_NUM_PSEL) begin
            s_d.thr[w[`LQTA_D_PSEL_HI:`LQTA_D_PSEL_LO]][w[`LQTA_D_HL]] = w[7:0];
          end
        end
        `LQTA_IDX_VAR: begin
          s_d.var_restart = w[`LQTA_V_RST];
        end
        default: begin
          s_d.var_restart = s_q.var_restart;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; thresholds and sample start at the documented byte
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.psel <= `LQTA_PSEL_RST;
      s_q.sample <= `LQTA_THR_RST;
      s_q.thr <= {12{`LQTA_THR_RST}};
      s_q.armed <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from the state register
  assign avs_readdata = s_q.rdata;
  assign monitor_irq = s_q.irq;
  assign dsp_restart = s_q.restart;
  assign link_drop = s_q.link_drop;

endmodule : lqta_top

`default_nettype wire

// file: inc/lqta_regs.svh
// Register indices, field positions and reset values of the link quality
// threshold access block. Byte address of a register is four times its index.
// Assumes inclusion by bare name from files that use the lqta_ prefix.
`ifndef LQTA_REGS_SVH
`define LQTA_REGS_SVH

// Register indices
`define LQTA_IDX_MON 5'h1d
`define LQTA_IDX_DATA 5'h1e
`define LQTA_IDX_VAR 5'h1f

// Data register fields
`define LQTA_D_SAMPLE 13
`define LQTA_D_WRCMD 12
`define LQTA_D_PSEL_HI 11
`define LQTA_D_PSEL_LO 9
`define LQTA_D_HL 8

// Monitor register fields
`define LQTA_M_EN 15
`define LQTA_M_RST_LO 10

// Variance register fields
`define LQTA_V_RST 10
`define LQTA_V_WARN 1

// Reset values and limits
`define LQTA_THR_RST 8'h80
`define LQTA_PSEL_RST 3'h0
`define LQTA_NUM_PSEL 3'h6

`endif

// file: inc/lqta_pkg.sv
// Types shared by the link quality threshold access block.
// Assumes nothing beyond a SystemVerilog compiler.
package lqta_pkg;

  // Avalon-MM request from the bus master
  typedef struct packed {
    logic read;
    logic write;
    logic [6:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } lqta_avmm_req_t;

  // Live adapted DSP parameters; chan index equals the parameter select code
  typedef struct packed {
    logic [4:0][7:0] chan;
    logic [31:0] variance;
  } lqta_params_t;

  // Parameter select codes
  typedef enum logic [2:0] {
    LQTA_PSEL_EQ = 3'h0,
    LQTA_PSEL_GAIN = 3'h1,
    LQTA_PSEL_BLW = 3'h2,
    LQTA_PSEL_FOFF = 3'h3,
    LQTA_PSEL_FCTL = 3'h4,
    LQTA_PSEL_VAR = 3'h5
  } lqta_psel_t;

  // Whole state of the register bank
  typedef struct packed {
    logic mon_en;
    logic [4:0] mon_restart;
    logic [9:0] mon_warn;
    logic var_restart;
    logic var_warn;
    logic sample_en;
    logic [2:0] psel;
    logic hl;
    logic [7:0] sample;
    logic [5:0][1:0][7:0] thr;
    logic [4:0] prev_hi;
    logic [4:0] prev_lo;
    logic prev_var;
    logic armed;
    logic irq;
    logic restart;
    logic link_drop;
    logic [31:0] rdata;
  } lqta_state_t;

  // State of the bus handshake
  typedef struct packed {
    logic ack;
  } lqta_ack_state_t;

endpackage : lqta_pkg

// file: rtl/lqta_thr_cmp.sv
// Threshold comparator for one monitored parameter.
// Assumes value and thresholds come from logic on the same clock.
`timescale 1ns/1ns
`default_nettype none

module lqta_thr_cmp #(
  parameter int W = 8
) (
  // Monitored value
  input wire logic [W-1:0] value,
  // Thresholds
  input wire logic [W-1:0] low,
  input wire logic [W-1:0] high,
  // Violations
  output logic above,
  output logic below
);

  ////////////////////////////////////////////////////////////////////////////
  // Strict compares so a threshold at the extreme disables its warning
  assign above = value > high;
  assign below = value < low;

endmodule : lqta_thr_cmp

`default_nettype wire

// file: rtl/lqta_avmm_ack.sv
// Avalon-MM handshake: one wait state, then the access completes.
// Assumes the master holds its request until waitrequest is seen low.
`timescale 1ns/1ns
`default_nettype none

module lqta_avmm_ack (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Request from master
  input wire logic req,
  // Handshake
  output logic waitrequest,
  output logic prep,
  output logic take
);

  lqta_pkg::lqta_ack_state_t s_q;
  lqta_pkg::lqta_ack_state_t s_d;

  ////////////////////////////////////////////////////////////////////////////
  // Ack rises one cycle after the request and drops after the completing edge
  always_comb begin
    s_d = s_q;
    s_d.ack = req & ~s_q.ack;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Wait state gives the bank a cycle to register read data
  assign waitrequest = req & ~s_q.ack;
  assign prep = req & ~s_q.ack;
  assign take = req & s_q.ack;

endmodule : lqta_avmm_ack

`default_nettype wire

// file: tb/lqta_top_properties.sv
// Checker for the link quality register bank: bus timing, reserved bits,
// interrupt and restart outputs. Assumes it is bound to lqta_top.
`timescale 1ns/1ns
`default_nettype none

module lqta_top_chk (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Bus
  input wire lqta_pkg::lqta_avmm_req_t avs_req,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Status and outputs
  input wire logic link_up_100,
  input wire logic monitor_irq_enable,
  input wire logic monitor_irq,
  input wire logic dsp_restart,
  input wire logic link_drop
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////
  // Completed reads at any address; each check below decodes its register
  logic rd_done;
  assign rd_done = avs_req.read && !avs_waitrequest;

  // One wait state, none while idle
  chk_wait_one: assert property ((avs_req.read || avs_req.write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("wait state too long");
  chk_wait_idle: assert property (!(avs_req.read || avs_req.write) |-> !avs_waitrequest)
    else $error("waitrequest while idle");
  // Reserved and command bits read zero
  chk_data_rsvd: assert property (rd_done && avs_req.address == 7'h78
    |-> avs_readdata[15:14] == 2'h0 && !avs_readdata[12])
    else $error("data register reserved bits set");
  chk_var_rsvd: assert property (rd_done && avs_req.address == 7'h7c
    |-> avs_readdata[15:11] == 5'h0 && avs_readdata[9:2] == 8'h0 && !avs_readdata[0])
    else $error("variance register reserved bits set");
  // Interrupt needs enable and a live link, holds until monitor read
  chk_irq_cause: assert property ($rose(monitor_irq)
    |-> $past(monitor_irq_enable) && $past(link_up_100))
    else $error("interrupt without enable or link");
  chk_irq_hold: assert property (monitor_irq && !(rd_done && avs_req.address == 7'h74)
    |=> monitor_irq)
    else $error("interrupt dropped without monitor read");
  // Restart is a pulse, link drop only beside it
  chk_restart_pulse: assert property (dsp_restart |=> !dsp_restart)
    else $error("restart longer than one cycle");
  chk_drop_pair: assert property (link_drop |-> dsp_restart && $past(link_up_100))
    else $error("link drop without restart");

  // Main scenarios
  cov_restart: cover property (dsp_restart);
  cov_drop: cover property (link_drop);
  cov_irq: cover property ($rose(monitor_irq));
endmodule : lqta_top_chk

bind lqta_top lqta_top_chk u_chk (
  .clk_sys(clk_sys),
  .rst_n(rst_n),
  .avs_req(avs_req),
  .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest),
  .link_up_100(link_up_100),
  .monitor_irq_enable(monitor_irq_enable),
  .monitor_irq(monitor_irq),
  .dsp_restart(dsp_restart),
  .link_drop(link_drop)
);

`default_nettype wire

// file: tb/tb_link_quality_threshold_access.sv
// Self-checking bench for lqta_top: thresholds, sampling, warnings, restart.
// Assumes the checker file is compiled alongside.
`timescale 1ns/1ns
`default_nettype none

module tb_link_quality_threshold_access;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  lqta_pkg::lqta_avmm_req_t req = '0;
  lqta_pkg::lqta_params_t params = '0;
  logic link_up = 1'b0;
  logic pd = 1'b0;
  logic opt = 1'b0;
  logic irq_en = 1'b0;
  logic [31:0] rdata;
  logic wait_req;
  logic irq;
  logic rst_p;
  logic drop_p;
  logic [31:0] q;
  int mismatches = 0;
  int compares = 0;
  int n_rst = 0;
  int n_drop = 0;

  ////////////////////////////////////////////////////////////////////////
  // 50 MHz clock
  always #10 clk_sys = ~clk_sys;

  lqta_top u_dut (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .avs_req(req),
    .avs_readdata(rdata),
    .avs_waitrequest(wait_req),
    .params(params),
    .link_up_100(link_up),
    .powered_down(pd),
    .signal_detect_option(opt),
    .monitor_irq_enable(irq_en),
    .monitor_irq(irq),
    .dsp_restart(rst_p),
    .link_drop(drop_p)
  );

  // Pulses are one cycle, so count them rather than poll
  always @(posedge clk_sys) begin
    if (rst_p === 1'b1) n_rst++;
    if (drop_p === 1'b1) n_drop++;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // One access; holds the request until waitrequest is sampled low
  task automatic bus(input logic r, input logic [6:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    req <= {r, ~r, a, 16'h0, d, 4'hf};
    do begin
      @(posedge clk_sys);
      n++;
    end while (wait_req !== 1'b0 && n < 50);
    q = rdata;
    req <= '0;
    if (n >= 50) begin
      mismatches++;
      report_and_stop();
    end
  endtask : bus

  // Stored threshold pattern per parameter and side
  function automatic logic [7:0] thr(input int p, input int h);
    return h ? 8'hf0 + 8'(p) : 8'h10 + 8'(p);
  endfunction : thr

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    // Reset values and an unmapped place
    bus(1'b1, 7'h78, 16'h0);
    chk("data reset", q, 32'h80);
    bus(1'b1, 7'h7c, 16'h0);
    chk("variance reset", q, 32'h0);
    bus(1'b1, 7'h00, 16'h0);
    chk("unmapped", q, 32'h0);
    $display("test reset done");
    // Every select code and side, reserved bits written high
    for (int p = 0; p < 6; p++) begin
      for (int h = 0; h < 2; h++) begin
        bus(1'b0, 7'h78, {4'hd, 3'(p), 1'(h), thr(p, h)});
      end
    end
    for (int p = 0; p < 6; p++) begin
      for (int h = 0; h < 2; h++) begin
        bus(1'b0, 7'h78, {4'h0, 3'(p), 1'(h), 8'h0});
        bus(1'b1, 7'h78, 16'h0);
        chk("threshold", q, {20'h0, 3'(p), 1'(h), thr(p, h)});
      end
    end
    // Select code six has no threshold: write dropped, byte reads zero
    bus(1'b0, 7'h78, 16'h1c44);
    bus(1'b1, 7'h78, 16'h0);
    chk("select six", q, 32'h0c00);
    $display("test thresholds done");
    // Powered down writes are dropped
    pd <= 1'b1;
    bus(1'b0, 7'h78, 16'h1044);
    pd <= 1'b0;
    // A misaligned write must not reach the data register either
    bus(1'b0, 7'h7a, 16'h1044);
    bus(1'b0, 7'h78, 16'h0);
    bus(1'b1, 7'h78, 16'h0);
    chk("powered down", q, {24'h0, thr(0, 0)});
    $display("test power down done");
    // Sampling holds its value; variance bytes
    params.chan[2] <= 8'h5a;
    params.variance <= 32'habcd_0000;
    bus(1'b0, 7'h78, 16'h2400);
    params.chan[2] <= 8'h33;
    bus(1'b1, 7'h78, 16'h0);
    chk("sample", q, 32'h245a);
    bus(1'b0, 7'h78, 16'h2b00);
    bus(1'b1, 7'h78, 16'h0);
    chk("variance high byte", q, 32'h2bab);
    bus(1'b0, 7'h78, 16'h2a00);
    bus(1'b1, 7'h78, 16'h0);
    chk("variance low byte", q, 32'h2acd);
    params <= {{5{8'h80}}, 32'h0};
    bus(1'b0, 7'h78, 16'h0);
    $display("test sampling done");
    // Monitor: high violation, restart with link drop
    link_up <= 1'b1;
    irq_en <= 1'b1;
    bus(1'b0, 7'h74, 16'h8400);
    bus(1'b1, 7'h74, 16'h0);
    chk("monitor quiet", q, 32'h8400);
    params.chan[0] <= 8'hf8;
    repeat (3) @(posedge clk_sys);
    chk("irq set", irq, 1'b1);
    params.chan[0] <= 8'h80;
    bus(1'b1, 7'h7c, 16'h0);
    chk("irq after variance read", irq, 1'b1);
    bus(1'b1, 7'h74, 16'h0);
    chk("high warning", q, 32'h8402);
    @(posedge clk_sys);
    chk("irq cleared", irq, 1'b0);
    bus(1'b1, 7'h74, 16'h0);
    chk("warning cleared", q, 32'h8400);
    chk("restart count", n_rst, 32'd1);
    chk("drop count", n_drop, 32'd1);
    $display("test monitor done");
    // Variance violation with signal detect option set
    opt <= 1'b1;
    bus(1'b0, 7'h7c, 16'hffff);
    params.variance <= 32'hf616_0000;
    repeat (3) @(posedge clk_sys);
    params.variance <= 32'h0;
    bus(1'b1, 7'h7c, 16'h0);
    chk("variance warning", q, 32'h0402);
    bus(1'b1, 7'h7c, 16'h0);
    chk("variance cleared", q, 32'h0400);
    chk("variance restart", n_rst, 32'd2);
    chk("no drop", n_drop, 32'd1);
    $display("test variance done");
    // Low warning with interrupt disabled and no restart bit, then link down
    bus(1'b1, 7'h74, 16'h0);
    chk("monitor after variance", q, 32'h8400);
    irq_en <= 1'b0;
    params.chan[3] <= 8'h00;
    repeat (3) @(posedge clk_sys);
    chk("irq disabled", irq, 1'b0);
    params.chan[3] <= 8'h80;
    link_up <= 1'b0;
    params.chan[1] <= 8'hff;
    repeat (3) @(posedge clk_sys);
    link_up <= 1'b1;
    params.chan[1] <= 8'h80;
    bus(1'b1, 7'h74, 16'h0);
    chk("low warning only", q, 32'h8440);
    chk("no restart", n_rst, 32'd2);
    $display("test low warning done");
    report_and_stop();
  end
endmodule : tb_link_quality_threshold_access

`default_nettype wire
